//--- verilog/rtac_pkg.sv
/*
  Shared constants for the clock's alarm, fixed-cycle timer and control register set.
  Assumes a 20 MHz system clock and a plain one-cycle register port.
*/
// Function
// RULE1: alarm registers at 8, 9, A with disable
// RULE2: alarm match sets alarm flag, pulls interrupt
// RULE3: 12-bit timer preset split over B and C
// RULE4: timer event when counter steps one to zero
// RULE5: unused timer preset acts as plain storage
// RULE6: factory test bits read zero, writes ignored
// RULE7: target select picks day or week field
// RULE8: timer enable starts and stops the timer
// RULE9: frequency select plus pin picks clock output
// RULE10: source select picks one of four periods
// RULE11: periods 4096 Hz, 64 Hz, 1 Hz, per minute
// RULE12: timer event sets timer flag bit 4
// RULE13: alarm event sets alarm flag bit 3
// RULE14: voltage-low flag sets on loss, holds
// RULE15: voltage-low write one ignored, zero clears
// RULE16: software reinitialises after voltage-low flag
// RULE17: timer irq enable gates timer interrupt
// RULE18: alarm irq enable gates alarm interrupt
// RULE19: stop bit halts clock and calendar counting
// RULE20: clearing timer flag or enable releases output
// RULE21: field disable bit makes field always match
// RULE22: flags clear on write zero, one ignored
package rtac_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0] ADDR_ALARM_MIN  = 4'h8;
  localparam logic [3:0] ADDR_ALARM_HOUR = 4'h9;
  localparam logic [3:0] ADDR_ALARM_WD   = 4'hA;
  localparam logic [3:0] ADDR_TPRE_LO    = 4'hB;
  localparam logic [3:0] ADDR_TPRE_HI    = 4'hC;
  localparam logic [3:0] ADDR_EXT        = 4'hD;
  localparam logic [3:0] ADDR_FLAGS      = 4'hE;
  localparam logic [3:0] ADDR_CTRL       = 4'hF;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_FIELD_DIS   = 7;
  localparam int BIT_TARGET_SEL  = 6;
  localparam int BIT_TIMER_EN    = 4;
  localparam int BIT_FSEL_HI     = 3;
  localparam int BIT_FSEL_LO     = 2;
  localparam int BIT_TSEL_HI     = 1;
  localparam int BIT_TSEL_LO     = 0;
  localparam int BIT_TIMER_FLAG  = 4;
  localparam int BIT_ALARM_FLAG  = 3;
  localparam int BIT_VLOW_FLAG   = 1;
  localparam int BIT_TIMER_IE    = 4;
  localparam int BIT_ALARM_IE    = 3;
  localparam int BIT_STOP        = 1;
  // writable bit masks; factory bits and zeros excluded
  localparam logic [7:0] MASK_EXT   = 8'h5F;
  localparam logic [7:0] MASK_CTRL  = 8'h1A;
  localparam logic [7:0] MASK_HI    = 8'hFF;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_EXT    = 8'h00;
  localparam logic [11:0] RST_TPRE  = 12'h001;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ          = 20000000;
  localparam int SRC0_HZ         = 4096;
  localparam int SRC1_HZ         = 64;
  localparam int SRC2_HZ         = 1;
  localparam int SRC3_PER_MIN_S  = 60;
  localparam int DIV4096_CYC     = CLK_HZ / SRC0_HZ;
  localparam int TRTN0_NS        = 122000;
  localparam int TRTN1_NS        = 7813000;
  localparam int CLK_NS          = 50;
  localparam int TRTN0_CYC       = TRTN0_NS / CLK_NS;
  localparam int TRTN1_CYC       = TRTN1_NS / CLK_NS;
  localparam int DIV64_STEPS     = SRC0_HZ / SRC1_HZ;
  localparam int DIV1_STEPS      = SRC1_HZ / SRC2_HZ;
  // timer source encodings
  typedef enum logic [1:0] {
    SRC_4096 = 2'b00,
    SRC_64   = 2'b01,
    SRC_1HZ  = 2'b10,
    SRC_MIN  = 2'b11
  } rtac_src_type;
endpackage

//--- verilog/rtac_regs.sv
/*
  Alarm, fixed-cycle timer, flag and control registers of the real-time clock.
  Assumes a host on a one-cycle register port; time of day arrives from the counters.
*/
`timescale 1ns/1ps
module rtac_regs
  import rtac_pkg::*;
#(
  parameter int TRTN_SHORT_CYC = TRTN0_CYC,
  parameter int TRTN_LONG_CYC  = TRTN1_CYC,
  parameter int DIV_CYC        = DIV4096_CYC
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rdata,
  input  wire logic [6:0]  cur_minute,
  input  wire logic [5:0]  cur_hour,
  input  wire logic [6:0]  cur_weekday,
  input  wire logic [5:0]  cur_date,
  input  wire logic        minute_tick,
  input  wire logic        supply_loss,
  input  wire logic        clkout_enable_pin,
  output logic             counter_stop,
  output logic [1:0]       clkout_sel,
  output logic             clkout_active,
  output logic             irq_n_out,
  output logic             irq_n_oe
);
  // ************************************************************
  // register storage
  // ************************************************************
  logic [7:0]  alarm_minute_reg;
  logic [7:0]  alarm_hour_reg;
  logic [7:0]  alarm_wd_reg;
  logic [11:0] tpre_reg;
  logic [3:0]  tpre_ram_reg;
  logic [7:0]  ext_reg;
  logic        timer_event_flag_reg;
  logic        alarm_event_flag_reg;
  logic        voltage_low_flag_reg;
  logic [7:0]  ctrl_reg;
  logic [11:0] tcount_reg;
  logic [11:0] tcount_next;
  logic        te_prev_reg;
  logic        match_prev_reg;
  logic [12:0] div_reg;
  logic [5:0]  sub64_reg;
  logic [5:0]  sub1_reg;
  logic        irq_t_reg;
  logic        irq_a_reg;
  logic [17:0] rtn_reg;
  logic [7:0]  rdata_reg;
  logic        stop_reg;
  logic [1:0]  fsel_reg;
  logic        clk_act_reg;

  // ************************************************************
  // decode
  // ************************************************************
  wire wr_amin  = wr_stb && (addr == ADDR_ALARM_MIN);
  wire wr_ahour = wr_stb && (addr == ADDR_ALARM_HOUR);
  wire wr_awd   = wr_stb && (addr == ADDR_ALARM_WD);
  wire wr_tlo   = wr_stb && (addr == ADDR_TPRE_LO);
  wire wr_thi   = wr_stb && (addr == ADDR_TPRE_HI);
  wire wr_ext   = wr_stb && (addr == ADDR_EXT);
  wire wr_flags = wr_stb && (addr == ADDR_FLAGS);
  wire wr_ctrl  = wr_stb && (addr == ADDR_CTRL);

  wire timer_en  = ext_reg[BIT_TIMER_EN];
  wire target_dt = ext_reg[BIT_TARGET_SEL];
  wire [1:0] tsel = {ext_reg[BIT_TSEL_HI], ext_reg[BIT_TSEL_LO]};
  wire timer_ie  = ctrl_reg[BIT_TIMER_IE];
  wire alarm_ie  = ctrl_reg[BIT_ALARM_IE];

  // ************************************************************
  // alarm compare
  // ************************************************************
  // a disabled field matches any value
  wire min_ok  = alarm_minute_reg[BIT_FIELD_DIS] ||
                 (alarm_minute_reg[6:0] == cur_minute); // RULE21
  wire hour_ok = alarm_hour_reg[BIT_FIELD_DIS] ||
                 (alarm_hour_reg[5:0] == cur_hour); // RULE21
  wire wk_ok   = |(alarm_wd_reg[6:0] & cur_weekday);
  wire dt_ok   = (alarm_wd_reg[5:0] == cur_date);
  wire wd_ok   = alarm_wd_reg[BIT_FIELD_DIS] || (target_dt ? dt_ok : wk_ok); // RULE7
  wire match_now   = min_ok && hour_ok && wd_ok;
  // edge only, so a held match fires once and a cleared flag stays clear
  wire alarm_event = match_now && !match_prev_reg; // RULE2

  // ************************************************************
  // timer source clocks
  // ************************************************************
  wire tick4096 = (div_reg == 13'(DIV_CYC - 1));
  wire tick64   = tick4096 && (sub64_reg == 6'(DIV64_STEPS - 1));
  wire tick1    = tick64 && (sub1_reg == 6'(DIV1_STEPS - 1));
  logic src_tick;
  always_comb begin
    case (tsel) // RULE10 RULE11
      SRC_4096: src_tick = tick4096;
      SRC_64:   src_tick = tick64;
      SRC_1HZ:  src_tick = tick1;
      SRC_MIN:  src_tick = minute_tick;
      default:  src_tick = 1'b0;
    endcase
  end

  // ************************************************************
  // down counter
  // ************************************************************
  wire te_rise     = timer_en && !te_prev_reg;
  wire timer_event = timer_en && !te_rise && src_tick &&
                     (tcount_reg == 12'h001); // RULE4
  always_comb begin
    if (!timer_en || te_rise) begin
      tcount_next = tpre_reg; // RULE8
    end else if (src_tick) begin
      tcount_next = (tcount_reg == 12'h001) ? tpre_reg : tcount_reg - 12'h001;
    end else begin
      tcount_next = tcount_reg;
    end
  end

  // ************************************************************
  // interrupt output
  // ************************************************************
  wire [17:0] rtn_len = (tsel == SRC_4096) ? 18'(TRTN_SHORT_CYC) : 18'(TRTN_LONG_CYC);
  wire flag_clr_t = wr_flags && !wdata[BIT_TIMER_FLAG];
  wire flag_clr_a = wr_flags && !wdata[BIT_ALARM_FLAG];
  wire ie_clr_t   = wr_ctrl && !wdata[BIT_TIMER_IE];
  wire ie_clr_a   = wr_ctrl && !wdata[BIT_ALARM_IE];
  wire stop_t     = wr_ext && !wdata[BIT_TIMER_EN];
  wire irq_t_next = (timer_event && timer_ie) ? 1'b1 : // RULE17
                    (flag_clr_t || ie_clr_t || stop_t || rtn_reg == 18'h00001) ? 1'b0 :
                    irq_t_reg; // RULE20
  wire irq_a_next = (alarm_event && alarm_ie) ? 1'b1 : // RULE18
                    (flag_clr_a || ie_clr_a) ? 1'b0 : irq_a_reg;

  // ************************************************************
  // readback
  // ************************************************************
  // factory test bits always read zero here
  logic [7:0] rd_mux;
  always_comb begin
    case (addr) // RULE6
      ADDR_ALARM_MIN:  rd_mux = alarm_minute_reg;
      ADDR_ALARM_HOUR: rd_mux = alarm_hour_reg;
      ADDR_ALARM_WD:   rd_mux = alarm_wd_reg;
      ADDR_TPRE_LO:    rd_mux = timer_en ? tpre_reg[7:0] : tcount_reg[7:0];
      ADDR_TPRE_HI:    rd_mux = {tpre_ram_reg, timer_en ? tpre_reg[11:8] : tcount_reg[11:8]};
      ADDR_EXT:        rd_mux = ext_reg & MASK_EXT;
      ADDR_FLAGS:      rd_mux = {3'h0, timer_event_flag_reg, alarm_event_flag_reg,
                                 1'b0, voltage_low_flag_reg, 1'b0};
      ADDR_CTRL:       rd_mux = ctrl_reg & MASK_CTRL;
      default:         rd_mux = RST_BYTE;
    endcase
  end

  // ************************************************************
  // register writes
  // ************************************************************
  // alarm and preset storage; preset doubles as ram when timer idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      alarm_minute_reg <= RST_BYTE;
      alarm_hour_reg   <= RST_BYTE;
      alarm_wd_reg     <= RST_BYTE;
      tpre_reg         <= RST_TPRE;
      tpre_ram_reg     <= 4'h0;
    end else begin
      if (wr_amin)  alarm_minute_reg <= wdata; // RULE1
      if (wr_ahour) alarm_hour_reg   <= wdata; // RULE1
      if (wr_awd)   alarm_wd_reg     <= wdata; // RULE1
      if (wr_tlo)   tpre_reg[7:0]    <= wdata; // RULE3 RULE5
      if (wr_thi)   tpre_reg[11:8]   <= wdata[3:0]; // RULE3
      // upper nibble of the high preset byte is plain storage only
      if (wr_thi)   tpre_ram_reg     <= wdata[7:4]; // RULE5
    end
  end

  // extension and control; factory bits never stored
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_reg  <= RST_EXT;
      ctrl_reg <= RST_BYTE;
    end else begin
      if (wr_ext)  ext_reg  <= wdata & MASK_EXT; // RULE6 RULE8
      if (wr_ctrl) ctrl_reg <= wdata & MASK_CTRL; // RULE6
    end
  end

  // sticky flags: the set wins over a same-cycle clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_event_flag_reg <= 1'b0;
      alarm_event_flag_reg <= 1'b0;
      voltage_low_flag_reg <= 1'b1;
    end else begin
      if (timer_event)     timer_event_flag_reg <= 1'b1; // RULE12
      else if (flag_clr_t) timer_event_flag_reg <= 1'b0; // RULE22
      if (alarm_event)     alarm_event_flag_reg <= 1'b1; // RULE13
      else if (flag_clr_a) alarm_event_flag_reg <= 1'b0; // RULE22
      if (supply_loss)     voltage_low_flag_reg <= 1'b1; // RULE14
      else if (wr_flags && !wdata[BIT_VLOW_FLAG]) voltage_low_flag_reg <= 1'b0; // RULE15
    end
  end

  // source divider and countdown
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_reg        <= 13'h0000;
      sub64_reg      <= 6'h00;
      sub1_reg       <= 6'h00;
      tcount_reg     <= RST_TPRE;
      te_prev_reg    <= 1'b0;
      match_prev_reg <= 1'b0;
    end else begin
      div_reg        <= tick4096 ? 13'h0000 : div_reg + 13'h0001;
      if (tick4096) sub64_reg <= tick64 ? 6'h00 : sub64_reg + 6'h01;
      if (tick64)   sub1_reg  <= tick1 ? 6'h00 : sub1_reg + 6'h01;
      tcount_reg     <= tcount_next;
      te_prev_reg    <= timer_en;
      match_prev_reg <= match_now;
    end
  end

  // interrupt hold timer: timer interrupt self-releases after the return time
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_t_reg <= 1'b0;
      irq_a_reg <= 1'b0;
      rtn_reg   <= 18'h00000;
    end else begin
      irq_t_reg <= irq_t_next;
      irq_a_reg <= irq_a_next;
      if (timer_event && timer_ie) rtn_reg <= rtn_len;
      else if (rtn_reg != 18'h00000) rtn_reg <= rtn_reg - 18'h00001;
    end
  end

  // registered pin and side outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_n_oe    <= 1'b0;
      rdata_reg   <= RST_BYTE;
      stop_reg    <= 1'b0;
      fsel_reg    <= 2'b00;
      clk_act_reg <= 1'b0;
    end else begin
      irq_n_oe    <= irq_t_next || irq_a_next; // RULE2 RULE20
      if (rd_stb) rdata_reg <= rd_mux;
      stop_reg    <= ctrl_reg[BIT_STOP]; // RULE19
      fsel_reg    <= {ext_reg[BIT_FSEL_HI], ext_reg[BIT_FSEL_LO]}; // RULE9
      clk_act_reg <= clkout_enable_pin; // RULE9
    end
  end

  assign rdata         = rdata_reg;
  assign irq_n_out     = 1'b0;
  assign counter_stop  = stop_reg;
  assign clkout_sel    = fsel_reg;
  assign clkout_active = clk_act_reg;

  // ************************************************************
  // checks
  // ************************************************************
  AST_TFLAG_SET: assert property (@(posedge mclk) disable iff (!nrst)
    timer_event |=> timer_event_flag_reg) // RULE12
    else $error("timer flag not set after event");
  AST_AFLAG_SET: assert property (@(posedge mclk) disable iff (!nrst)
    alarm_event |=> alarm_event_flag_reg) // RULE13
    else $error("alarm flag not set after event");
  AST_VLF_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    (voltage_low_flag_reg && !(wr_flags && !wdata[BIT_VLOW_FLAG])) |=> voltage_low_flag_reg) // RULE15
    else $error("voltage flag dropped without a zero write");
  AST_IRQ_TIMER: assert property (@(posedge mclk) disable iff (!nrst)
    (timer_event && timer_ie) |=> irq_n_oe) // RULE17
    else $error("interrupt not driven on timer event");
  AST_IRQ_ALARM: assert property (@(posedge mclk) disable iff (!nrst)
    (alarm_event && alarm_ie) |=> irq_n_oe) // RULE18
    else $error("interrupt not driven on alarm event");
  AST_IRQ_RELEASE: assert property (@(posedge mclk) disable iff (!nrst)
    (ie_clr_t && !timer_event && !irq_a_next) |=> !irq_n_oe) // RULE20
    else $error("interrupt not released on enable clear");
  AST_TIMER_STEP: assert property (@(posedge mclk) disable iff (!nrst)
    timer_event |=> (tcount_reg == $past(tpre_reg))) // RULE4
    else $error("counter did not reload after event");
  AST_TIMER_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    !timer_en |=> !timer_event) // RULE8
    else $error("timer event while disabled");
  AST_STOP_OUT: assert property (@(posedge mclk) disable iff (!nrst)
    (wr_ctrl && wdata[BIT_STOP]) |=> ##1 counter_stop) // RULE19
    else $error("stop output not raised");
endmodule

//--- bench/rtac_host_model.sv
/*
  Host side of the register port: a one-cycle master with write and read
  tasks, plus the pull-up that resolves the open-drain interrupt line.
  Assumes one bench process calls the tasks, never two at once.
*/
`timescale 1ns/1ps
module rtac_host_model
  import rtac_pkg::*;
(
  input  wire logic       mclk,
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_stb,
  output logic            rd_stb,
  input  wire logic [7:0] rdata,
  input  wire logic       irq_n_out,
  input  wire logic       irq_n_oe,
  output logic            irq_line
);
  // ****************************************************************
  // pin and bus driving
  // ****************************************************************
  // pull-up wins unless the device sinks the line
  assign irq_line = irq_n_oe ? irq_n_out : 1'b1;

  // quiet bus at time zero
  initial begin
    addr   = 4'h0;
    wdata  = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // one-cycle write; released lines flip so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    addr   <= ~a;
    wdata  <= ~d;
  endtask

  // one-cycle read; data becomes valid in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    addr   <= ~a;
    @(negedge mclk);
    d = rdata;
  endtask
endmodule

//--- bench/rtac_regs_tb.sv
/*
  Self-checking bench for the alarm, timer, flag and control registers.
  Assumes the host model drives the register port; short timing parameters.
*/
`timescale 1ns/1ps
module rtac_regs_tb
  import rtac_pkg::*;
;
  // ****************************************************************
  // signals, design and host
  // ****************************************************************
  logic mclk, nrst, wr_stb, rd_stb, minute_tick, supply_loss, clkout_enable_pin;
  logic counter_stop, clkout_active, irq_n_out, irq_n_oe, irq_line;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [6:0] cur_minute, cur_weekday;
  logic [5:0] cur_hour, cur_date;
  logic [1:0] clkout_sel;
  int err_total, checked, cyc, n_cyc;

  rtac_regs #(.TRTN_SHORT_CYC(20), .TRTN_LONG_CYC(50), .DIV_CYC(8)) i_dut (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .cur_minute(cur_minute), .cur_hour(cur_hour),
    .cur_weekday(cur_weekday), .cur_date(cur_date), .minute_tick(minute_tick),
    .supply_loss(supply_loss), .clkout_enable_pin(clkout_enable_pin),
    .counter_stop(counter_stop), .clkout_sel(clkout_sel),
    .clkout_active(clkout_active), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

  rtac_host_model i_host (
    .mclk(mclk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_line(irq_line));

  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // hang guard: the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(what, exp, d);
  endtask

  // bounded wait for the interrupt output enable to reach a level, sampled settled
  task automatic wait_oe(input logic v, input int lim, input string what, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (irq_n_oe !== v && n < lim);
    chk(what, {7'h00, v}, {7'h00, irq_n_oe});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rdchk(ADDR_FLAGS, 8'h02, "flags_rst");
    rdchk(ADDR_EXT, 8'h00, "ext_rst");
    rdchk(ADDR_CTRL, 8'h00, "ctrl_rst");
    rdchk(4'h3, 8'h00, "unmapped");
    chk("oe_rst", 8'h00, {7'h00, irq_n_oe});
  endtask

  task automatic t_vlow;
    i_host.wr(ADDR_FLAGS, 8'hFF);
    rdchk(ADDR_FLAGS, 8'h02, "flags_w1");
    i_host.wr(ADDR_FLAGS, 8'h00);
    rdchk(ADDR_FLAGS, 8'h00, "vlow_clr");
    @(posedge mclk);
    supply_loss <= 1'b1;
    @(posedge mclk);
    supply_loss <= 1'b0;
    rdchk(ADDR_FLAGS, 8'h02, "vlow_set");
    i_host.wr(ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_storage;
    i_host.wr(ADDR_CTRL, 8'h00);
    i_host.wr(ADDR_EXT, 8'h00);
    i_host.wr(ADDR_ALARM_MIN, 8'hD9);
    i_host.wr(ADDR_ALARM_HOUR, 8'hE3);
    i_host.wr(ADDR_ALARM_WD, 8'h7F);
    rdchk(ADDR_ALARM_MIN, 8'hD9, "al_min");
    rdchk(ADDR_ALARM_HOUR, 8'hE3, "al_hour");
    rdchk(ADDR_ALARM_WD, 8'h7F, "al_wd");
    // per-minute source with no tick keeps the preset still while read
    i_host.wr(ADDR_TPRE_LO, 8'h3C);
    i_host.wr(ADDR_TPRE_HI, 8'hA5);
    i_host.wr(ADDR_EXT, 8'h13);
    rdchk(ADDR_TPRE_LO, 8'h3C, "pre_lo");
    rdchk(ADDR_TPRE_HI, 8'hA5, "pre_hi");
    i_host.wr(ADDR_EXT, 8'hFF);
    rdchk(ADDR_EXT, 8'h5F, "ext_mask");
    chk("fsel", 8'h03, {6'h00, clkout_sel});
    i_host.wr(ADDR_CTRL, 8'hFF);
    rdchk(ADDR_CTRL, 8'h1A, "ctrl_mask");
    chk("stop_on", 8'h01, {7'h00, counter_stop});
    i_host.wr(ADDR_CTRL, 8'h00);
    repeat (3) @(negedge mclk);
    chk("stop_off", 8'h00, {7'h00, counter_stop});
    i_host.wr(ADDR_EXT, 8'h00);
    clkout_enable_pin <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("clk_act", 8'h01, {7'h00, clkout_active});
    @(posedge mclk);
    clkout_enable_pin <= 1'b0;
  endtask

  task automatic t_timer;
    // the storage pattern matched the alarm and left its flag set
    i_host.wr(ADDR_FLAGS, 8'h00);
    i_host.wr(ADDR_TPRE_LO, 8'h08);
    i_host.wr(ADDR_TPRE_HI, 8'h00);
    i_host.wr(ADDR_CTRL, 8'h10);
    i_host.wr(ADDR_EXT, 8'h10);
    wait_oe(1'b1, 100, "tmr_irq", n_cyc);
    chk("irq_pin", 8'h00, {7'h00, irq_line});
    rdchk(ADDR_FLAGS, 8'h10, "tf_set");
    wait_oe(1'b0, 30, "tmr_auto", n_cyc);
    wait_oe(1'b1, 100, "tmr_irq2", n_cyc);
    i_host.wr(ADDR_FLAGS, 8'h00);
    wait_oe(1'b0, 3, "tf_release", n_cyc);
    wait_oe(1'b1, 100, "tmr_irq3", n_cyc);
    i_host.wr(ADDR_CTRL, 8'h00);
    wait_oe(1'b0, 3, "tie_release", n_cyc);
    i_host.wr(ADDR_FLAGS, 8'h00);
    // longer than one timer period, so at least one masked event falls inside
    n_cyc = 0;
    repeat (100) begin
      @(negedge mclk);
      if (irq_n_oe !== 1'b0) n_cyc++;
    end
    chk("tie_off", 8'h00, n_cyc[7:0]);
    chk("tie_pin", 8'h01, {7'h00, irq_line});
    rdchk(ADDR_FLAGS, 8'h10, "tf_masked");
    i_host.wr(ADDR_EXT, 8'h00);
    i_host.wr(ADDR_FLAGS, 8'h00);
    repeat (150) @(posedge mclk);
    rdchk(ADDR_FLAGS, 8'h00, "te_off");
  endtask

  task automatic t_sources;
    int per;
    for (int s = 0; s < 4; s += (s == 1) ? 2 : 1) begin
      per = (s == 0) ? 8 : 512;
      i_host.wr(ADDR_TPRE_LO, 8'h02);
      i_host.wr(ADDR_FLAGS, 8'h00);
      i_host.wr(ADDR_CTRL, 8'h10);
      i_host.wr(ADDR_EXT, {6'h04, s[1:0]});
      if (s == 3) begin
        repeat (2) begin
          n_cyc = 0;
          repeat (20) begin
            @(negedge mclk);
            if (irq_n_oe !== 1'b0) n_cyc++;
          end
          chk("min_early", 8'h00, n_cyc[7:0]);
          @(posedge mclk);
          minute_tick <= 1'b1;
          @(posedge mclk);
          minute_tick <= 1'b0;
        end
        wait_oe(1'b1, 5, "min_src", n_cyc);
      end else begin
        wait_oe(1'b1, 1100, "src_irq", n_cyc);
        chk("src_time", 8'h01, {7'h00, n_cyc + 4 >= per && n_cyc <= 2 * per + 8});
      end
      i_host.wr(ADDR_EXT, 8'h00);
      i_host.wr(ADDR_CTRL, 8'h00);
    end
  endtask

  task automatic t_alarm;
    i_host.wr(ADDR_FLAGS, 8'h00);
    i_host.wr(ADDR_CTRL, 8'h08);
    i_host.wr(ADDR_ALARM_MIN, 8'h15);
    i_host.wr(ADDR_ALARM_HOUR, 8'h08);
    i_host.wr(ADDR_ALARM_WD, 8'h04);
    cur_minute <= 7'h15;
    wait_oe(1'b1, 5, "al_irq", n_cyc);
    rdchk(ADDR_FLAGS, 8'h08, "af_set");
    chk("af_hold", 8'h01, {7'h00, irq_n_oe});
    i_host.wr(ADDR_FLAGS, 8'h00);
    wait_oe(1'b0, 3, "af_clr", n_cyc);
    i_host.wr(ADDR_ALARM_MIN, 8'h80);
    i_host.wr(ADDR_ALARM_WD, 8'h12);
    i_host.wr(ADDR_EXT, 8'h40);
    cur_date <= 6'h12;
    wait_oe(1'b1, 5, "day_irq", n_cyc);
    i_host.wr(ADDR_CTRL, 8'h00);
    i_host.wr(ADDR_FLAGS, 8'h00);
    wait_oe(1'b0, 3, "aie_clr", n_cyc);
    @(posedge mclk);
    cur_date <= 6'h11;
    @(posedge mclk);
    cur_date <= 6'h12;
    repeat (5) @(negedge mclk);
    chk("aie_off", 8'h00, {7'h00, irq_n_oe});
    rdchk(ADDR_FLAGS, 8'h08, "af_masked");
  endtask

  // main sequence: reset held for four cycles, then every scenario
  initial begin
    err_total = 0;
    checked = 0;
    cyc = 0;
    nrst = 1'b0;
    minute_tick = 1'b0;
    supply_loss = 1'b0;
    clkout_enable_pin = 1'b0;
    cur_minute = 7'h14;
    cur_hour = 6'h08;
    cur_weekday = 7'h04;
    cur_date = 6'h11;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_vlow();
    t_storage();
    t_timer();
    t_sources();
    t_alarm();
    print_verdict();
  end
endmodule
